// [core/sacc_pkg.sv]
// Shared constants, register layouts and types for the converter control block
package sacc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [4:0] SACC_OFS_INSEL = 5'h00;
  localparam logic [4:0] SACC_OFS_CTRLA = 5'h04;
  localparam logic [4:0] SACC_OFS_CTRLB = 5'h08;
  localparam logic [4:0] SACC_OFS_RESLO = 5'h0c;
  localparam logic [4:0] SACC_OFS_RESHI = 5'h10;
  localparam logic [4:0] SACC_OFS_PWR = 5'h14;

  // ==========================================================================
  // Widths and reset values
  localparam int SACC_RES_W = 10;
  localparam int SACC_TRIG_N = 6;
  localparam logic [7:0] SACC_INSEL_RST = 8'h00;
  localparam logic [2:0] SACC_PS_RST = 3'h0;
  localparam logic [2:0] SACC_TS_RST = 3'h0;
  localparam logic SACC_PWR_RST = 1'b0;

  // ==========================================================================
  // Conversion timing in converter clock cycles
  localparam logic [4:0] SACC_LEN_NORMAL = 5'h0d;
  localparam logic [4:0] SACC_LEN_FIRST = 5'h19;
  // Ticks from end of sampling to completion: ten decisions plus the finish
  localparam logic [4:0] SACC_SAR_SPAN = 5'h0b;
  localparam logic [3:0] SACC_SAR_MSB = 4'h9;
  localparam logic [9:0] SACC_SAR_FIRST = 10'h200;
  // Prescaler divides by this base shifted left by the prescale code
  localparam logic [8:0] SACC_DIV_BASE = 9'h002;

  // ==========================================================================
  // Trigger source codes
  localparam logic [2:0] SACC_TS_FREE = 3'h0;
  localparam logic [2:0] SACC_TS_FIRST_LINE = 3'h1;
  localparam logic [2:0] SACC_TS_LAST_LINE = 3'h6;

  // ==========================================================================
  // Register layouts
  typedef struct packed {
    logic [1:0] reference_select;
    logic left_justify_select;
    logic reserved;
    logic [3:0] channel_select;
  } sacc_insel_t;

  typedef struct packed {
    logic converter_enable;
    logic start_conversion;
    logic auto_trigger_enable;
    logic conversion_done_flag;
    logic irq_enable;
    logic [2:0] prescale;
  } sacc_ctrla_t;

  typedef struct packed {
    logic [3:0] channel_select;
    logic [1:0] reference_select;
  } sacc_route_t;

  typedef enum logic [0:0] {
    SACC_IDLE = 1'b0,
    SACC_CONV = 1'b1
  } sacc_state_t;

endpackage

// [core/sacc_core.sv]
// Successive-approximation converter control with Avalon-MM register slave
//
// Functional notes
// - Ten-bit result by successive approximation; zero is ground, all ones reference less one.
// - Channel field picks eight external inputs, ground or bandgap.
// - Reference field routes supply or internal 1.1V onto reference pin.
// - Channel and reference selections reach the analog side only while enabled.
// - Converter works only while its power-reduction bit is zero.
// - Result right-justified by default, left-justified when justify bit set.
// - Low byte read blocks result updates; high byte read releases them.
// - Conversion ending while blocked discards its result, both bytes untouched.
// - Done flag still rises when the result was discarded.
// - Converter raises its own completion interrupt when a conversion finishes.
// - Writing start begins one conversion; bit stays set until completion.
// - Channel change during conversion applies only after it completes.
// - Auto-trigger enable activates triggering; source field picks event line.
// - Rising edge of selected trigger resets prescaler and starts conversion.
// - Trigger still high at completion starts nothing; needs fresh edge.
// - Trigger edges during a conversion are ignored, never queued.
// - Source flags set regardless of enables; software clears before retrigger.
// - Done flag as source restarts conversion at each completion.
// - Free running starts via start bit, continues regardless of flag.
// - Start bit still launches a single conversion with auto-trigger on.
// - Start bit reads one during any conversion.
// - Normal conversion 13 converter clocks; first after enable 25.
// - Prescaler counts while enabled, held in reset while disabled.
// - Start-bit request begins at next prescaled converter clock edge.
// - Completion writes result, sets flag, clears start in single mode.
`timescale 1ns/1ps

module sacc_core
  import sacc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [SACC_TRIG_N-1:0] trig_i,
  input wire logic comp_i,
  output logic analog_en_o,
  output logic [3:0] channel_select_o,
  output logic [1:0] reference_select_o,
  output logic [SACC_RES_W-1:0] dac_code_o,
  output logic sample_o,
  output logic conv_done_irq_o
);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] sacc_justify(input logic [SACC_RES_W-1:0] r,
                                               input logic left);
    logic [15:0] v;
    v = left ? {r, 6'h00} : {6'h00, r};
    return v;
  endfunction

  function automatic logic sacc_line(input logic [2:0] ts,
                                     input logic [SACC_TRIG_N-1:0] lines);
    logic v;
    logic [2:0] idx;
    v = 1'b0;
    idx = ts - SACC_TS_FIRST_LINE;
    if (ts >= SACC_TS_FIRST_LINE && ts <= SACC_TS_LAST_LINE) begin
      v = lines[idx];
    end
    return v;
  endfunction

  // ==========================================================================
  // Declarations
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rd_done;
  logic wr_done;
  sacc_insel_t insel_q;
  sacc_ctrla_t wr_a;
  logic en_q;
  logic auto_q;
  logic flag_q;
  logic ie_q;
  logic [2:0] ps_q;
  logic [2:0] ts_q;
  logic pwr_q;
  logic run;
  logic [7:0] pre_q;
  logic [8:0] div_last;
  logic tick;
  logic trig_prev_q;
  logic trig_line;
  logic trig_start;
  logic pend_q;
  logic go;
  sacc_state_t state_q;
  logic [4:0] t_q;
  logic [4:0] t_next;
  logic [4:0] len;
  logic [4:0] offset;
  logic first_q;
  logic done_now;
  logic free_run;
  logic [SACC_RES_W-1:0] sar_q;
  logic [3:0] bit_q;
  logic comp_m_q;
  logic comp_s_q;
  logic [SACC_RES_W-1:0] res_q;
  logic lock_q;
  sacc_route_t route_q;
  logic [15:0] just;
  logic busy;
  logic an_en_q;
  logic samp_q;
  logic irq_q;

  // ==========================================================================
  // Bus slave: one wait state per access
  assign rd_done = avs_read_i & ~wait_q;
  assign wr_done = avs_write_i & ~wait_q & avs_byteenable_i[0];
  assign wr_a = avs_writedata_i[7:0];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i | avs_write_i) & wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign just = sacc_justify(res_q, insel_q.left_justify_select);
  assign busy = pend_q | (state_q == SACC_CONV);

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (avs_address_i)
      SACC_OFS_INSEL: rdata_d[7:0] = insel_q;
      SACC_OFS_CTRLA: rdata_d[7:0] = {en_q, busy, auto_q, flag_q, ie_q, ps_q};
      SACC_OFS_CTRLB: rdata_d[2:0] = ts_q;
      SACC_OFS_RESLO: rdata_d[7:0] = just[7:0];
      SACC_OFS_RESHI: rdata_d[7:0] = just[15:8];
      SACC_OFS_PWR: rdata_d[0] = pwr_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i & wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      insel_q <= SACC_INSEL_RST;
    end else if (wr_done && avs_address_i == SACC_OFS_INSEL) begin
      insel_q <= {wr_a[7:5], 1'b0, wr_a[3:0]};
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_q <= 1'b0;
      auto_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= SACC_PS_RST;
    end else if (wr_done && avs_address_i == SACC_OFS_CTRLA) begin
      en_q <= wr_a.converter_enable;
      auto_q <= wr_a.auto_trigger_enable;
      ie_q <= wr_a.irq_enable;
      ps_q <= wr_a.prescale;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ts_q <= SACC_TS_RST;
      pwr_q <= SACC_PWR_RST;
    end else if (wr_done) begin
      if (avs_address_i == SACC_OFS_CTRLB) begin
        ts_q <= avs_writedata_i[2:0];
      end
      if (avs_address_i == SACC_OFS_PWR) begin
        pwr_q <= avs_writedata_i[0];
      end
    end
  end

  // Done flag: hardware set wins over write-one clear
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_q <= 1'b0;
    end else if (done_now) begin
      flag_q <= 1'b1;
    end else if (wr_done && avs_address_i == SACC_OFS_CTRLA && wr_a.conversion_done_flag) begin
      flag_q <= 1'b0;
    end
  end

  assign run = en_q & ~pwr_q;

  // ==========================================================================
  // Converter clock prescaler
  assign div_last = (SACC_DIV_BASE << ps_q) - 9'h001;
  assign tick = run & ({1'b0, pre_q} == div_last);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_q <= 8'h00;
    end else if (!run || trig_start || tick) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // ==========================================================================
  // Trigger edge detection
  assign trig_line = sacc_line(ts_q, trig_i);
  // Edges count only while idle, so edges in a conversion are dropped
  assign trig_start = run & auto_q & (state_q == SACC_IDLE) & (ts_q != SACC_TS_FREE)
                    & trig_line & ~trig_prev_q;
  assign free_run = auto_q & (ts_q == SACC_TS_FREE);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_line;
    end
  end

  // ==========================================================================
  // Start request held until the next converter clock edge
  assign go = trig_start | (pend_q & tick & (state_q == SACC_IDLE));

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
    end else if (wr_done && avs_address_i == SACC_OFS_CTRLA && wr_a.start_conversion
                 && wr_a.converter_enable && !pwr_q && !busy && !go) begin
      // Enable and start in one write must not lose the request
      pend_q <= 1'b1;
    end else if (!run || go) begin
      pend_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Conversion sequencing
  assign len = first_q ? SACC_LEN_FIRST : SACC_LEN_NORMAL;
  assign offset = len - SACC_SAR_SPAN;
  assign t_next = t_q + 5'h01;
  assign done_now = (state_q == SACC_CONV) & tick & (t_next == len);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= SACC_IDLE;
      t_q <= 5'h00;
    end else if (!run) begin
      state_q <= SACC_IDLE;
      t_q <= 5'h00;
    end else begin
      unique case (state_q)
        SACC_IDLE: begin
          if (go) begin
            state_q <= SACC_CONV;
            t_q <= 5'h00;
          end
        end
        SACC_CONV: begin
          if (done_now) begin
            t_q <= 5'h00;
            // Free running restarts at once, otherwise start bit falls
            state_q <= free_run ? SACC_CONV : SACC_IDLE;
          end else if (tick) begin
            t_q <= t_next;
          end
        end
      endcase
    end
  end

  // First conversion after enable takes the long path
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_q <= 1'b1;
    end else if (!run) begin
      first_q <= 1'b1;
    end else if (done_now) begin
      first_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Comparator synchroniser
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comp_m_q <= 1'b0;
      comp_s_q <= 1'b0;
    end else begin
      comp_m_q <= comp_i;
      comp_s_q <= comp_m_q;
    end
  end

  // ==========================================================================
  // Successive approximation register
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sar_q <= '0;
      bit_q <= SACC_SAR_MSB;
    end else if (state_q == SACC_CONV && tick) begin
      if (t_next == offset) begin
        sar_q <= SACC_SAR_FIRST;
        bit_q <= SACC_SAR_MSB;
      end else if (t_next > offset && t_next < len) begin
        // Comparator low means input below trial code: drop the bit
        if (!comp_s_q) begin
          sar_q[bit_q] <= 1'b0;
        end
        if (bit_q != 4'h0) begin
          sar_q[bit_q - 4'h1] <= 1'b1;
          bit_q <= bit_q - 4'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Result registers and read lock
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_q <= 1'b0;
    end else if (rd_done && avs_address_i == SACC_OFS_RESLO) begin
      lock_q <= 1'b1;
    end else if (rd_done && avs_address_i == SACC_OFS_RESHI) begin
      lock_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_q <= '0;
    end else if (done_now && !lock_q
                 && !(avs_read_i && avs_address_i == SACC_OFS_RESLO)) begin
      // Low byte read in flight counts as locked
      res_q <= sar_q;
    end
  end

  // ==========================================================================
  // Analog routing, locked while converting
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_q <= '0;
    end else if (run && (state_q == SACC_IDLE || done_now)) begin
      route_q.channel_select <= insel_q.channel_select;
      route_q.reference_select <= insel_q.reference_select;
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      an_en_q <= 1'b0;
      samp_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      an_en_q <= run;
      samp_q <= (state_q == SACC_CONV) && (t_q < offset);
      irq_q <= flag_q & ie_q;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign analog_en_o = an_en_q;
  assign channel_select_o = route_q.channel_select;
  assign reference_select_o = route_q.reference_select;
  assign dac_code_o = sar_q;
  assign sample_o = samp_q;
  assign conv_done_irq_o = irq_q;

endmodule

// [tb/sacc_core_monitor.sv]
// Port-level assertions for the converter control block
`timescale 1ns/1ps

module sacc_core_monitor (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic analog_en_o,
  input wire logic [3:0] channel_select_o,
  input wire logic [1:0] reference_select_o,
  input wire logic sample_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  // Request seen while stalled, and two cycles of converter off
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_off2;
    !analog_en_o ##1 !analog_en_o;
  endsequence

  a_wait_single: assert property (s_req |=> !avs_waitrequest_o)
    else $error("waitrequest not released one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("waitrequest low without request");
  a_rd_upper_zero: assert property (
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rd_data_hold: assert property (
    $changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
    else $error("read data changed outside a read");
  a_route_hold_off: assert property (
    s_off2 |-> $stable(channel_select_o) && $stable(reference_select_o))
    else $error("routing changed while converter off");
  a_route_hold_samp: assert property (
    sample_o && $past(sample_o) |-> $stable(channel_select_o))
    else $error("channel changed while sampling");
  a_off_no_sample: assert property (s_off2 |-> !sample_o)
    else $error("sampling while converter off");
endmodule

bind sacc_core sacc_core_monitor mon (
  .clock_i(clock_i),
  .rst_b_i(rst_b_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .analog_en_o(analog_en_o),
  .channel_select_o(channel_select_o),
  .reference_select_o(reference_select_o),
  .sample_o(sample_o)
);

// [tb/sacc_afe_model.sv]
// Analog front end and on-chip trigger source model
`timescale 1ns/1ps

module sacc_afe_model
  import sacc_pkg::*;
(
  input wire logic clock_i,
  input wire logic analog_en_i,
  input wire logic [3:0] channel_i,
  input wire logic [SACC_RES_W-1:0] dac_i,
  output logic comp_o,
  output logic [SACC_TRIG_N-1:0] trig_o
);
  logic [9:0] vin;

  initial comp_o = 1'b0;
  initial trig_o = '0;
  // Ground reads zero, other inputs a fixed level per channel
  assign vin = (channel_i == 4'hf) ? 10'h000 : 10'(channel_i * 10'h075 + 10'h021);

  // Comparator one clock late; when unpowered it toggles rather than holding
  always @(posedge clock_i) begin
    comp_o <= analog_en_i ? (vin >= dac_i) : ~comp_o;
  end

  task automatic pulse(input int idx, input int hi);
    @(posedge clock_i);
    trig_o[idx] <= 1'b1;
    repeat (hi) @(posedge clock_i);
    trig_o[idx] <= 1'b0;
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps

module tb_top;
  import sacc_pkg::*;
  logic clock_i, rst_b_i, avs_read_i, avs_write_i, comp_i;
  logic sample_o, conv_done_irq_o, analog_en_o, avs_waitrequest_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [SACC_TRIG_N-1:0] trig_i;
  logic [3:0] channel_select_o;
  logic [1:0] reference_select_o;
  logic [SACC_RES_W-1:0] dac_code_o;
  int bad_count = 0;
  int check_count = 0;
  int c;

  sacc_core uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'h1), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .trig_i(trig_i), .comp_i(comp_i),
    .analog_en_o(analog_en_o), .channel_select_o(channel_select_o),
    .reference_select_o(reference_select_o), .dac_code_o(dac_code_o),
    .sample_o(sample_o), .conv_done_irq_o(conv_done_irq_o));
  sacc_afe_model afe (.clock_i(clock_i), .analog_en_i(analog_en_o),
    .channel_i(channel_select_o), .dac_i(dac_code_o), .comp_o(comp_i), .trig_o(trig_i));

  // ==========================================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    // Pre-edge values are what the master samples at this edge
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0 && ++n < 50);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50) bad_count++;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, exp});
  endtask

  task automatic wait_done();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, SACC_OFS_CTRLA, 8'h00, q);
      n++;
    end while (q[4] !== 1'b1 && n < 200);
    check(q[4], 1'b1);
  endtask

  // Start one conversion and count cycles until the interrupt rises
  task automatic timed(input logic [7:0] d);
    wr(SACC_OFS_CTRLA, d);
    c = 0;
    while (conv_done_irq_o !== 1'b1 && c < 400) begin
      @(posedge clock_i);
      c++;
    end
  endtask

  task automatic conv(input logic [7:0] sel);
    wr(SACC_OFS_INSEL, sel);
    wr(SACC_OFS_CTRLA, 8'h99);
    wr(SACC_OFS_CTRLA, 8'hc9);
    wait_done();
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    summarize();
  end

  initial begin
    rst_b_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rdc(SACC_OFS_INSEL, SACC_INSEL_RST);
    rdc(SACC_OFS_CTRLA, 8'h00);
    rdc(SACC_OFS_CTRLB, {5'h0, SACC_TS_RST});
    rdc(SACC_OFS_PWR, {7'h0, SACC_PWR_RST});
    wr(5'h18, 8'hff);
    rdc(5'h18, 8'h00);
    wr(SACC_OFS_PWR, 8'h01);
    rdc(SACC_OFS_PWR, 8'h01);
    wr(SACC_OFS_CTRLA, 8'hc1);
    repeat (20) @(posedge clock_i);
    check(analog_en_o, 1'b0);
    wr(SACC_OFS_CTRLA, 8'h01);
    wr(SACC_OFS_PWR, 8'h00);
    wr(SACC_OFS_INSEL, 8'h47);
    repeat (4) @(posedge clock_i);
    check(channel_select_o, 4'h0);
    timed(8'hc9);
    check(c >= 98 && c <= 106, 1'b1);
    check({reference_select_o, channel_select_o}, 6'h17);
    check(conv_done_irq_o, 1'b1);
    rdc(SACC_OFS_CTRLA, 8'h99);
    rdc(SACC_OFS_RESLO, 8'h54);
    rdc(SACC_OFS_RESHI, 8'h03);
    wr(SACC_OFS_INSEL, 8'h45);
    wr(SACC_OFS_CTRLA, 8'h99);
    wr(SACC_OFS_CTRLA, 8'hc9);
    repeat (4) @(posedge clock_i);
    wr(SACC_OFS_INSEL, 8'h46);
    rdc(SACC_OFS_CTRLA, 8'hc9);
    wait_done();
    rdc(SACC_OFS_RESLO, 8'h6a);
    rdc(SACC_OFS_RESHI, 8'h02);
    wr(SACC_OFS_CTRLA, 8'h99);
    timed(8'hc9);
    check(c >= 50 && c <= 58, 1'b1);
    rdc(SACC_OFS_RESLO, 8'hdf);
    conv(8'h42);
    rdc(SACC_OFS_CTRLA, 8'h99);
    rdc(SACC_OFS_RESHI, 8'h02);
    conv(8'h42);
    rdc(SACC_OFS_RESLO, 8'h0b);
    rdc(SACC_OFS_RESHI, 8'h01);
    wr(SACC_OFS_INSEL, 8'h62);
    rdc(SACC_OFS_RESHI, 8'h42);
    conv(8'h63);
    rdc(SACC_OFS_RESHI, 8'h60);
    rdc(SACC_OFS_RESLO, 8'h00);
    rdc(SACC_OFS_RESHI, 8'h60);
    wr(SACC_OFS_INSEL, 8'h03);
    wr(SACC_OFS_CTRLB, 8'h02);
    wr(SACC_OFS_CTRLA, 8'hb1);
    afe.pulse(0, 4);
    repeat (80) @(posedge clock_i);
    rdc(SACC_OFS_CTRLA, 8'ha1);
    afe.pulse(1, 4);
    rdc(SACC_OFS_CTRLA, 8'he1);
    fork
      afe.pulse(1, 150);
      begin
        repeat (70) @(posedge clock_i);
        rdc(SACC_OFS_CTRLA, 8'hb1);
      end
    join
    rdc(SACC_OFS_CTRLA, 8'hb1);
    check(conv_done_irq_o, 1'b0);
    wr(SACC_OFS_CTRLA, 8'hb1);
    repeat (80) @(posedge clock_i);
    rdc(SACC_OFS_CTRLA, 8'ha1);
    for (int i = 1; i <= 6; i++) begin
      wr(SACC_OFS_CTRLB, 8'(i));
      afe.pulse(i - 1, 2);
      wait_done();
      wr(SACC_OFS_CTRLA, 8'hb1);
    end
    wr(SACC_OFS_CTRLB, 8'h07);
    for (int i = 0; i < 6; i++) afe.pulse(i, 2);
    repeat (80) @(posedge clock_i);
    rdc(SACC_OFS_CTRLA, 8'ha1);
    wr(SACC_OFS_CTRLA, 8'he1);
    wait_done();
    wr(SACC_OFS_CTRLB, 8'h00);
    wr(SACC_OFS_CTRLA, 8'he1);
    repeat (300) @(posedge clock_i);
    rdc(SACC_OFS_CTRLA, 8'hf1);
    wr(SACC_OFS_CTRLA, 8'hf1);
    repeat (300) @(posedge clock_i);
    rdc(SACC_OFS_CTRLA, 8'hf1);
    wr(SACC_OFS_CTRLA, 8'h01);
    repeat (4) @(posedge clock_i);
    check({analog_en_o, sample_o}, 2'b00);
    summarize();
  end
endmodule
